/* rtl/iop_port_regs.sv */
// Four-port I/O configuration and data registers with peripheral buffer mode.
// Assumes bus strobes and logic-array terms are synchronous to mclk;
// pad inputs are asynchronous and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
module iop_port_regs (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              rstn,
    // Microcontroller bus
    input  wire iop_pkg::iop_bus_t bus_req,
    input  wire logic [7:0]        lat_addr,
    output logic [7:0]             bus_rdata,
    output logic                   bus_rdata_oe,
    // Logic array
    input  wire logic              periph_select_a,
    input  wire logic              periph_select_b,
    input  wire iop_pkg::iop_ports_t oe_term,
    input  wire iop_pkg::iop_ports_t cell_next,
    input  wire iop_pkg::iop_ports_t cell_update,
    input  wire logic              icell_strobe,
    output iop_pkg::iop_ports_t    output_cell,
    output iop_pkg::iop_ports_t    input_cell,
    // Pads
    input  wire iop_pkg::iop_ports_t pad_in,
    output iop_pkg::iop_ports_t    pad_out,
    output iop_pkg::iop_ports_t    pad_oe,
    output iop_pkg::iop_ports_t    fast_slew
);
    iop_pkg::iop_ports_t mode_r;
    iop_pkg::iop_ports_t dir_r;
    iop_pkg::iop_ports_t drv_r;
    iop_pkg::iop_ports_t latch_r;
    iop_pkg::iop_ports_t mask_r;
    iop_pkg::iop_ports_t ocell_r;
    iop_pkg::iop_ports_t icell_r;
    iop_pkg::iop_ports_t sync1_r;
    iop_pkg::iop_ports_t pin_r;
    iop_pkg::iop_ports_t pad_out_r;
    iop_pkg::iop_ports_t pad_oe_r;
    iop_pkg::iop_ports_t slew_r;
    logic [7:0]          pmode_r;
    logic [7:0]          rdata_r;
    logic                rdata_oe_r;

    iop_pkg::iop_ports_t drv_en;
    iop_pkg::iop_ports_t src;
    iop_pkg::iop_ports_t oe_nxt;
    iop_pkg::iop_ports_t out_nxt;
    iop_pkg::iop_ports_t ocell_nxt;
    logic [7:0]          rmux;

    wire logic [3:0] kind     = bus_req.addr[7:iop_pkg::KIND_LSB];
    wire logic [1:0] pidx     = bus_req.addr[1:0];
    wire logic       reg_wr   = bus_req.io_sel & bus_req.wr; // [R04]
    wire logic       reg_rd   = bus_req.io_sel & bus_req.rd; // [R04]
    wire logic       periph_on  = pmode_r[iop_pkg::PMODE_BIT]; // [R01]
    wire logic       psel_any   = periph_select_a | periph_select_b;
    wire logic       periph_act = periph_on & psel_any;

    function automatic logic hit(input logic [3:0] k, input logic [1:0] p,
                                 input logic [3:0] kk, input logic [1:0] pp);
        hit = (k == kk) && (p == pp);
    endfunction : hit

    // Only ports with cells have an enable term and an enable status register.
    function automatic logic has_oe_term(input int p);
        has_oe_term = iop_pkg::HAS_CELL[p];
    endfunction : has_oe_term

    genvar g;
    generate
        for (g = 0; g < iop_pkg::NPORT; g++) begin : g_port
            wire logic wsel = reg_wr & hit(kind, pidx, iop_pkg::K_OCELL, 2'(g));
            wire logic [7:0] cbase = (cell_update[g] & cell_next[g])
                                   | (~cell_update[g] & ocell_r[g]);
            // Direction or enable term; port D has no enable term. [R09] [R08]
            assign drv_en[g] = (dir_r[g] | (has_oe_term(g) ? oe_term[g] : '0))
                             & iop_pkg::PIN_MASK[g];
            // Mode 1 sends the latched address, mode 0 the output latch. [R07] [R20] [R14]
            assign src[g] = iop_pkg::HAS_MODE[g]
                          ? ((mode_r[g] & lat_addr) | (~mode_r[g] & latch_r[g]))
                          : latch_r[g];
            // An open-drain pin only pulls low, so a one releases the pad. [R11]
            assign oe_nxt[g] = drv_en[g] & ~(drv_r[g] & iop_pkg::OD_MASK[g] & src[g]);
            assign out_nxt[g] = src[g];
            // A bus write loads unmasked cells and wins over the array update. [R15] [R16]
            assign ocell_nxt[g] = !iop_pkg::HAS_CELL[g] ? '0
                                : wsel ? ((bus_req.wdata & ~mask_r[g]) | (cbase & mask_r[g]))
                                : cbase;
        end
    endgenerate

    // Kinds that a port lacks read zero, so software can probe which registers exist.
    always_comb begin
        case (kind)
            iop_pkg::K_IN:     rmux = pin_r[pidx]; // [R13]
            iop_pkg::K_LATCH:  rmux = latch_r[pidx]; // [R14]
            iop_pkg::K_DIR:    rmux = dir_r[pidx];
            iop_pkg::K_DRIVE:  rmux = drv_r[pidx];
            iop_pkg::K_MODE:   rmux = mode_r[pidx];
            iop_pkg::K_OCELL:  rmux = ocell_r[pidx]; // [R15]
            iop_pkg::K_MASK:   rmux = mask_r[pidx];
            iop_pkg::K_ICELL:  rmux = icell_r[pidx]; // [R17]
            iop_pkg::K_OESTAT: rmux = has_oe_term(pidx) ? drv_en[pidx] : '0; // [R18]
            iop_pkg::K_PMODE:  rmux = (pidx == 2'h0) ? pmode_r : '0;
            default:           rmux = '0;
        endcase
    end

    // Pads cross two flops before anything reads them.
    // They carry no reset; the chain flushes within two cycles of release.
    always_ff @(posedge mclk) begin
        sync1_r <= pad_in;
        pin_r   <= sync1_r;
    end

    // Writes mask to implemented bits so unused bits read zero, except the peripheral mode register, which keeps all eight. [R05]
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            mode_r  <= {4{iop_pkg::REG_RST}}; // [R06]
            dir_r   <= {4{iop_pkg::REG_RST}}; // [R06] [R08]
            drv_r   <= {4{iop_pkg::REG_RST}}; // [R06]
            latch_r <= {4{iop_pkg::REG_RST}};
            mask_r  <= {4{iop_pkg::REG_RST}}; // [R16]
            pmode_r <= iop_pkg::REG_RST;
        end else if (reg_wr) begin
            case (kind)
                iop_pkg::K_LATCH: latch_r[pidx] <= bus_req.wdata & iop_pkg::PIN_MASK[pidx];
                iop_pkg::K_DIR:   dir_r[pidx] <= bus_req.wdata & iop_pkg::PIN_MASK[pidx]; // [R10]
                iop_pkg::K_DRIVE: drv_r[pidx] <= bus_req.wdata
                    & (iop_pkg::OD_MASK[pidx] | iop_pkg::SLEW_MASK[pidx]); // [R11] [R12]
                iop_pkg::K_MODE:  mode_r[pidx] <= iop_pkg::HAS_MODE[pidx]
                    ? bus_req.wdata : iop_pkg::REG_RST; // [R07]
                iop_pkg::K_MASK:  mask_r[pidx] <= iop_pkg::HAS_CELL[pidx]
                    ? bus_req.wdata : iop_pkg::REG_RST;
                iop_pkg::K_PMODE: if (pidx == 2'h0) pmode_r <= bus_req.wdata;
                default: ;
            endcase
        end
    end

    // A bus write and an array update in one cycle: unmasked bits take the bus value.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ocell_r <= '0;
            icell_r <= '0;
        end else begin
            ocell_r <= ocell_nxt;
            if (icell_strobe) begin
                for (int p = 0; p < iop_pkg::NPORT; p++) begin
                    icell_r[p] <= iop_pkg::HAS_CELL[p] ? pin_r[p] : '0; // [R17]
                end
            end
        end
    end

    // Pad drivers are registered so the pads never see decode glitches.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pad_out_r <= '0;
            pad_oe_r  <= '0;
            slew_r    <= '0;
        end else begin
            pad_out_r <= out_nxt;
            pad_oe_r  <= oe_nxt;
            for (int p = 0; p < iop_pkg::NPORT; p++) begin
                slew_r[p] <= drv_r[p] & iop_pkg::SLEW_MASK[p]; // [R12]
            end
            if (periph_on) begin
                // Buffer drives only on a selected write, else floats. [R01] [R02] [R03]
                pad_oe_r[0]  <= (periph_act & bus_req.wr) ? iop_pkg::ALL_ONES : '0;
                pad_out_r[0] <= bus_req.wdata;
            end
        end
    end

    // A peripheral read wins over a register read; software must not select both at once.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rdata_r    <= '0;
            rdata_oe_r <= 1'b0;
        end else begin
            rdata_oe_r <= (periph_act & bus_req.rd) | reg_rd;
            if (periph_act & bus_req.rd) begin
                rdata_r <= pin_r[0]; // [R03]
            end else if (reg_rd) begin
                rdata_r <= rmux;
            end
        end
    end

    assign bus_rdata    = rdata_r;
    assign bus_rdata_oe = rdata_oe_r;
    assign output_cell  = ocell_r;
    assign input_cell   = icell_r;
    assign pad_out      = pad_out_r;
    assign pad_oe       = pad_oe_r;
    assign fast_slew    = slew_r;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence s_cell_wr;
        reg_wr && kind == iop_pkg::K_OCELL && pidx == 2'h0;
    endsequence

    AST_PERIPH_WRITE: assert property ( // [R03]
        (periph_act && bus_req.wr) |=> (pad_oe_r[0] == 8'hFF)
            && (pad_out_r[0] == $past(bus_req.wdata)))
        else $error("peripheral write did not drive port A");
    AST_PERIPH_FLOAT: assert property ( // [R02]
        (periph_on && !psel_any) |=> (pad_oe_r[0] == 8'h00))
        else $error("port A driven without a select term");
    AST_PERIPH_READ: assert property ( // [R03]
        (periph_act && bus_req.rd) |=> bus_rdata_oe && (bus_rdata == $past(pin_r[0])))
        else $error("peripheral read did not return port A");
    AST_RESET_CFG: assert property ( // [R06]
        $rose(rstn) |-> (dir_r == '0) && (mode_r == '0) && (drv_r == '0) && (pad_oe_r == '0))
        else $error("configuration not zero after reset");
    AST_DIR_D: assert property ( // [R10]
        dir_r[3][7:3] == 5'h00)
        else $error("unimplemented port D direction bits set");
    AST_OE_B: assert property ( // [R09]
        1'b1 |=> ((pad_oe_r[1] & ~$past(dir_r[1] | oe_term[1])) == 8'h00)
            && (($past(dir_r[1] | oe_term[1]) & ~$past(drv_r[1] & iop_pkg::OD_MASK[1])
                & ~pad_oe_r[1]) == 8'h00))
        else $error("port B driver state wrong");
    AST_MASK_BLOCK: assert property ( // [R16]
        s_cell_wr |=> ((ocell_r[0] ^ $past(ocell_r[0]))
            & $past(mask_r[0] & ~cell_update[0])) == 8'h00)
        else $error("masked output cell was loaded");
    AST_CELL_LOAD: assert property ( // [R15]
        s_cell_wr |=> ((ocell_r[0] ^ $past(bus_req.wdata)) & ~$past(mask_r[0])) == 8'h00)
        else $error("unmasked output cell not loaded");
    AST_OESTAT: assert property ( // [R18]
        (!periph_act && reg_rd && kind == iop_pkg::K_OESTAT && pidx == 2'h2)
            |=> bus_rdata == $past(drv_en[2]))
        else $error("enable status read wrong");
    AST_PIN_READ: assert property ( // [R13]
        (!periph_act && reg_rd && kind == iop_pkg::K_IN && pidx == 2'h3)
            |=> bus_rdata == $past(pin_r[3]))
        else $error("pin input read wrong");
    AST_ICELL_HOLD: assert property ( // [R17]
        !icell_strobe |=> $stable(icell_r))
        else $error("input cell changed without strobe");
    AST_ADDR_OUT: assert property ( // [R20]
        (mode_r[1] == 8'hFF && drv_r[1] == 8'h00) |=> pad_out_r[1] == $past(lat_addr))
        else $error("port B not showing latched address");

    // Ports without a mode register, cells or upper drive bits must keep those bits at zero.
    AST_MODE_CD: assert property ( // [R07]
        (mode_r[2] == 8'h00) && (mode_r[3] == 8'h00))
        else $error("mode bits set on a port without a mode register");
    AST_CELLS_D: assert property ( // [R15]
        (ocell_r[3] == 8'h00) && (icell_r[3] == 8'h00) && (mask_r[3] == 8'h00))
        else $error("port D cell state not zero");
    AST_DRIVE_D: assert property ( // [R12]
        drv_r[3][7:3] == 5'h00)
        else $error("unused port D drive bits set");

    // Pad outputs lag the registers by one cycle, hence the past values.
    AST_SLEW_B: assert property ( // [R12]
        1'b1 |=> slew_r[1] == ($past(drv_r[1]) & iop_pkg::SLEW_MASK[1]))
        else $error("port B slew select wrong");
    AST_OPEN_DRAIN_C: assert property ( // [R11]
        1'b1 |=> (pad_oe_r[2] & $past(drv_r[2] & latch_r[2])) == 8'h00)
        else $error("open-drain pin on port C drove a one");
    AST_LATCH_OUT_C: assert property ( // [R14]
        1'b1 |=> pad_out_r[2] == $past(latch_r[2]))
        else $error("port C pad data differs from output latch");
    AST_OE_D: assert property ( // [R10]
        1'b1 |=> pad_oe_r[3] == $past(dir_r[3]))
        else $error("port D driver not following its direction bits");
    AST_DIR_OUT_A: assert property ( // [R08]
        (dir_r[0] == 8'hFF && drv_r[0] == 8'h00 && !periph_on) |=> pad_oe_r[0] == 8'hFF)
        else $error("port A output pins not driving");
    AST_ADDR_OUT_A: assert property ( // [R07]
        (mode_r[0] == 8'hFF && !periph_on) |=> pad_out_r[0] == $past(lat_addr))
        else $error("port A not showing latched address");
    AST_PERIPH_OFF: assert property ( // [R01]
        !periph_on |=> pad_oe_r[0] == $past(oe_nxt[0]))
        else $error("port A buffer active outside peripheral mode");

    // Every read is answered exactly one cycle later, and only then.
    sequence s_any_rd;
        reg_rd || (periph_act && bus_req.rd);
    endsequence

    sequence s_latch_wr_c;
        reg_wr && kind == iop_pkg::K_LATCH && pidx == 2'h2;
    endsequence

    AST_RDATA_OE: assert property ( // [R04]
        s_any_rd |=> bus_rdata_oe)
        else $error("read not answered in the next cycle");
    AST_RDATA_IDLE: assert property ( // [R04]
        !(reg_rd || (periph_act && bus_req.rd)) |=> !bus_rdata_oe)
        else $error("data bus driven without a read");
    AST_LATCH_WR: assert property ( // [R14]
        s_latch_wr_c |=> latch_r[2] == $past(bus_req.wdata))
        else $error("output latch write lost");
    AST_ICELL_CAPTURE: assert property ( // [R17]
        icell_strobe |=> icell_r[2] == $past(pin_r[2]))
        else $error("input cell missed its capture");
endmodule : iop_port_regs
`default_nettype wire

/* rtl/iop_pkg.sv */
// Constants and carrier types of the I/O port register block.
// Assumes an 8-bit bus interface that qualifies accesses with a region select.
// Behaviour
// R01 - Peripheral mode register bit 7 set turns port A into a data buffer.
// R02 - In peripheral mode port A floats while neither select term is active.
// R03 - Selected: writes drive port A from bus data, reads return port A.
// R04 - Registers are reached by plain reads and writes at fixed region offsets.
// R05 - Register bit n controls or reports only pin n of its port.
// R06 - Mode, direction and drive select registers reset to all zeros.
// R07 - Ports A and B mode bit: 0 bus I/O, 1 latched address out.
// R08 - Direction bit 1 makes an output, 0 an input; all inputs after reset.
// R09 - Ports A to C drive when direction bit or enable term is one.
// R10 - Port D direction register holds only its three low bits.
// R11 - Drive bit 1 selects open drain on A/B bits 7-4 and all of C.
// R12 - Drive bit 1 selects fast slew on A/B bits 3-0 and D bits 2-0.
// R13 - Pin input register reads the live pin levels.
// R14 - Output latch stores written data, drives enabled pins, reads back.
// R15 - Output cell register reads cell outputs; writes load unmasked cells.
// R16 - Mask bit 1 blocks loads into its output cell; resets to 0.
// R17 - Input cells capture pins, feed the logic array, and read back.
// R18 - Enable status reads each driver state, 1 driving, 0 floating; the code reads port D as zero.
// R19 - Software sets mode and direction bits both for address output.
// R20 - Latched address output presents address bits 7-0 on port B.
package iop_pkg;
    localparam int         NPORT     = 4;
    localparam int         PW        = 8;
    localparam int         KIND_LSB  = 4;
    localparam int         PMODE_BIT = 7;
    localparam logic [3:0] K_IN      = 4'h0;
    localparam logic [3:0] K_LATCH   = 4'h1;
    localparam logic [3:0] K_DIR     = 4'h2;
    localparam logic [3:0] K_DRIVE   = 4'h3;
    localparam logic [3:0] K_MODE    = 4'h4;
    localparam logic [3:0] K_OCELL   = 4'h5;
    localparam logic [3:0] K_MASK    = 4'h6;
    localparam logic [3:0] K_ICELL   = 4'h7;
    localparam logic [3:0] K_OESTAT  = 4'h8;
    localparam logic [3:0] K_PMODE   = 4'h9;
    localparam logic [7:0] REG_RST   = 8'h00;
    localparam logic [7:0] ALL_ONES  = 8'hFF;
    // Index 0 is port A, index 3 is port D.
    localparam logic [0:3]      HAS_MODE  = 4'hC;
    localparam logic [0:3]      HAS_CELL  = 4'hE;
    localparam logic [0:3][7:0] PIN_MASK  = {8'hFF, 8'hFF, 8'hFF, 8'h07};
    localparam logic [0:3][7:0] OD_MASK   = {8'hF0, 8'hF0, 8'hFF, 8'h00};
    localparam logic [0:3][7:0] SLEW_MASK = {8'h0F, 8'h0F, 8'h00, 8'h07};

    typedef struct packed {
        logic       io_sel;
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } iop_bus_t;

    typedef logic [0:3][7:0] iop_ports_t;
endpackage : iop_pkg

/* sim/iop_mcu_model.sv */
// Microcontroller bus master model facing the port register block.
// Assumes the bench calls xfer and that the block registers its answer on the same edge that takes a request.
`timescale 1ns/1ps
`default_nettype none
module iop_mcu_model (
    // Clock
    input  wire logic         mclk,
    // Bus
    output var iop_pkg::iop_bus_t bus_req,
    input  wire logic [7:0]   bus_rdata,
    input  wire logic         bus_rdata_oe
);
    initial bus_req = '0;

    // Idle address and data lines show the inverse of the last value so stale data never matches.
    task automatic xfer(input logic sel, input logic rw, input logic [7:0] ad,
                        input logic [7:0] wd, output logic [7:0] rv, output logic ov);
        @(posedge mclk);
        bus_req <= '{io_sel: sel, rd: rw, wr: !rw, addr: ad, wdata: wd};
        @(posedge mclk);
        bus_req <= '{io_sel: 1'b0, rd: 1'b0, wr: 1'b0, addr: ~ad, wdata: ~wd};
        #1;
        rv = bus_rdata;
        ov = bus_rdata_oe;
    endtask : xfer
endmodule : iop_mcu_model
`default_nettype wire

/* sim/tb.sv */
// Self-checking bench for the port register block.
// Assumes the bus model in iop_mcu_model and external pin levels from ext.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic               mclk;
    logic               rstn;
    iop_pkg::iop_bus_t  bus_req;
    logic [7:0]         lat_addr, bus_rdata, rv;
    logic               bus_rdata_oe, psa, psb, icell_strobe, ov;
    iop_pkg::iop_ports_t oe_term, cell_next, cell_update, output_cell, input_cell;
    iop_pkg::iop_ports_t pad_in, pad_out, pad_oe, fast_slew, ext;
    int                 n_errors = 0;
    int                 check_count = 0;

    // Undriven pins take the external level.
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext);

    iop_port_regs iop_port_regs_i (.mclk(mclk), .rstn(rstn), .bus_req(bus_req),
        .lat_addr(lat_addr), .bus_rdata(bus_rdata), .bus_rdata_oe(bus_rdata_oe),
        .periph_select_a(psa), .periph_select_b(psb), .oe_term(oe_term),
        .cell_next(cell_next), .cell_update(cell_update), .icell_strobe(icell_strobe),
        .output_cell(output_cell), .input_cell(input_cell), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .fast_slew(fast_slew));

    iop_mcu_model iop_mcu_model_i (.mclk(mclk), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .bus_rdata_oe(bus_rdata_oe));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk

    task automatic wr(input logic [3:0] k, input int p, input logic [7:0] d);
        logic [7:0] v;
        logic       o;
        iop_mcu_model_i.xfer(1'b1, 1'b0, {k, 2'b00, p[1:0]}, d, v, o);
    endtask : wr

    task automatic rd(input logic [3:0] k, input int p, input logic [7:0] e);
        logic [7:0] v;
        logic       o;
        iop_mcu_model_i.xfer(1'b1, 1'b1, {k, 2'b00, p[1:0]}, 8'h00, v, o);
        chk(v, e);
        chk({7'h00, o}, 8'h01);
    endtask : rd

    // Covers the pad register lag plus the two-flop pin synchroniser.
    task automatic settle();
        repeat (3) @(posedge mclk);
        #1;
    endtask : settle

    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up

    initial begin
        rstn = 1'b0;
        lat_addr = 8'h9E;
        {psa, psb, icell_strobe} = 3'h0;
        {oe_term, cell_next, cell_update} = '0;
        ext = {4{8'hC3}};
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        for (int p = 0; p < 4; p++) begin
            rd(iop_pkg::K_DIR, p, 8'h00);
            rd(iop_pkg::K_DRIVE, p, 8'h00);
            rd(iop_pkg::K_MODE, p, 8'h00);
            rd(iop_pkg::K_MASK, p, 8'h00);
            chk(pad_oe[p], 8'h00);
        end
        rd(4'hA, 0, 8'h00);
        for (int p = 0; p < 4; p++) begin
            wr(iop_pkg::K_DIR, p, 8'h0F);
            wr(iop_pkg::K_LATCH, p, 8'h3C);
            settle();
            rd(iop_pkg::K_DIR, p, 8'h0F & iop_pkg::PIN_MASK[p]);
            rd(iop_pkg::K_LATCH, p, 8'h3C & iop_pkg::PIN_MASK[p]);
            chk(pad_oe[p], 8'h0F & iop_pkg::PIN_MASK[p]);
            chk(pad_out[p] & pad_oe[p], 8'h0C & iop_pkg::PIN_MASK[p]);
            // Driven pins show the latch, the rest the external level; D has 3 pins.
            rd(iop_pkg::K_IN, p, (p < 3) ? 8'hCC : 8'hC4);
        end
        @(posedge mclk);
        oe_term[1] <= 8'hF0;
        oe_term[3] <= 8'hF0;
        settle();
        chk(pad_oe[1], 8'hFF);
        chk(pad_oe[3], 8'h07);
        rd(iop_pkg::K_OESTAT, 1, 8'hFF);
        rd(iop_pkg::K_OESTAT, 2, 8'h0F);
        rd(iop_pkg::K_OESTAT, 3, 8'h00);
        @(posedge mclk);
        oe_term <= '0;
        for (int p = 0; p < 4; p++) begin
            wr(iop_pkg::K_DRIVE, p, 8'hFF);
            wr(iop_pkg::K_DIR, p, 8'hFF);
            settle();
            chk(fast_slew[p], iop_pkg::SLEW_MASK[p]);
            chk(pad_oe[p], iop_pkg::PIN_MASK[p] & ~(iop_pkg::OD_MASK[p] & 8'h3C));
            wr(iop_pkg::K_DRIVE, p, 8'h00);
        end
        for (int p = 0; p < 3; p++) begin
            wr(iop_pkg::K_MASK, p, 8'h0F);
            rd(iop_pkg::K_MASK, p, 8'h0F);
            wr(iop_pkg::K_OCELL, p, 8'hFF);
            rd(iop_pkg::K_OCELL, p, 8'hF0);
            @(posedge mclk);
            cell_next[p] <= 8'h66;
            cell_update[p] <= 8'hFF;
            icell_strobe <= 1'b1;
            @(posedge mclk);
            cell_update[p] <= 8'h00;
            icell_strobe <= 1'b0;
            settle();
            chk(output_cell[p], 8'h66);
            chk(input_cell[p], 8'h3C);
            rd(iop_pkg::K_ICELL, p, 8'h3C);
        end
        wr(iop_pkg::K_MODE, 1, 8'hFF);
        wr(iop_pkg::K_MODE, 2, 8'hFF);
        settle();
        chk(pad_out[1], 8'h9E);
        rd(iop_pkg::K_MODE, 1, 8'hFF);
        rd(iop_pkg::K_MODE, 2, 8'h00);
        wr(iop_pkg::K_MODE, 1, 8'h00);
        settle();
        chk(pad_out[1], 8'h3C);
        wr(iop_pkg::K_MODE, 0, 8'hFF);
        settle();
        chk(pad_out[0], 8'h9E);
        wr(iop_pkg::K_MODE, 0, 8'h00);
        settle();
        chk(pad_out[0], 8'h3C);
        wr(iop_pkg::K_PMODE, 0, 8'h80);
        settle();
        chk(pad_oe[0], 8'h00);
        @(posedge mclk);
        psa <= 1'b1;
        iop_mcu_model_i.xfer(1'b0, 1'b0, 8'h00, 8'h5A, rv, ov);
        chk(pad_oe[0], 8'hFF);
        chk(pad_out[0], 8'h5A);
        @(posedge mclk);
        psa <= 1'b0;
        psb <= 1'b1;
        settle();
        iop_mcu_model_i.xfer(1'b0, 1'b1, 8'h00, 8'h00, rv, ov);
        chk(rv, 8'hC3);
        chk({7'h00, ov}, 8'h01);
        @(posedge mclk);
        psb <= 1'b0;
        settle();
        chk(pad_oe[0], 8'h00);
        wrap_up();
    end
endmodule : tb
`default_nettype wire
